// file: rtl/cmd_tree_consts.vh
`ifndef CMD_TREE_CONSTS_VH
`define CMD_TREE_CONSTS_VH

// common command opcodes, presented on cmd_op when cmd_common is high
`define OP_RCL     4'h0
`define OP_RST     4'h1
`define OP_SAV     4'h2
`define OP_SRE     4'h3
`define OP_SRE_Q   4'h4
`define OP_STB_Q   4'h5
`define OP_TST_Q   4'h6
`define OP_WAI     4'h7
`define OP_OPC     4'h8
`define OP_OPC_Q   4'h9

// slot and mask limits
`define RCL_MIN    16'sh0000
`define RCL_MAX    16'sh000a
`define SAV_MIN    16'sh0001
`define SAV_MAX    16'sh000a
`define SRE_MIN    16'sh0000
`define SRE_MAX    16'sh00ff
`define SLOT_COUNT 11
`define SLOT_DEF   4'h0

// status byte bit that carries the master summary
`define STB_MSS_BIT 6
`define STB_MSS_MSK 8'h40

// error codes reported on err_code
`define ERR_UNDEF_HDR 8'h7b
`define ERR_PARAM     8'he0

// header word codes
`define W_LAS 4'h1
`define W_TEC 4'h2
`define W_DIS 4'h3
`define W_OUT 4'h4
`define W_DEC 4'h5
`define W_SET 4'h6
`define W_R   4'h7
`define W_T   4'h8

// tree node codes, root is node 0
`define N_ROOT    4'h0
`define N_LAS     4'h1
`define N_TEC     4'h2
`define N_LAS_DIS 4'h3
`define N_LAS_OUT 4'h4
`define N_LAS_DEC 4'h5
`define N_LAS_DS  4'h6
`define N_TEC_DIS 4'h7
`define N_TEC_SET 4'h8
`define N_TEC_R   4'h9
`define N_TEC_DT  4'ha
`define N_TEC_SR  4'hb

// mask reset value and the "1" answer that ends a wait
`define SRE_RST   8'h00
`define RESP_ONE  16'h0001

`endif

// file: rtl/tree_lookup.v
`timescale 1ns/1ps
`include "cmd_tree_consts.vh"

// command tree: finds a child of a node by header word, and the parent of a node
module tree_lookup (
    input  wire [3:0] node,
    input  wire [3:0] word,
    input  wire [3:0] up_node,
    output reg        hit,
    output reg  [3:0] child,
    output reg  [3:0] parent
);

    // child search only looks one level below node, never across siblings
    always @* begin
        hit   = 1'b1;
        child = `N_ROOT;
        case ({node, word})
            {`N_ROOT, `W_LAS}:    child = `N_LAS;
            {`N_ROOT, `W_TEC}:    child = `N_TEC;
            {`N_LAS, `W_DIS}:     child = `N_LAS_DIS;
            {`N_LAS, `W_OUT}:     child = `N_LAS_OUT;
            {`N_LAS, `W_DEC}:     child = `N_LAS_DEC;
            {`N_LAS_DIS, `W_SET}: child = `N_LAS_DS;
            {`N_TEC, `W_DIS}:     child = `N_TEC_DIS;
            {`N_TEC, `W_SET}:     child = `N_TEC_SET;
            {`N_TEC, `W_R}:       child = `N_TEC_R;
            {`N_TEC_DIS, `W_T}:   child = `N_TEC_DT;
            {`N_TEC_SET, `W_R}:   child = `N_TEC_SR;
            default:              hit = 1'b0;
        endcase
    end

    // parent table used for the upward walk
    always @* begin
        case (up_node)
            `N_LAS, `N_TEC:                       parent = `N_ROOT;
            `N_LAS_DIS, `N_LAS_OUT, `N_LAS_DEC:   parent = `N_LAS;
            `N_LAS_DS:                            parent = `N_LAS_DIS;
            `N_TEC_DIS, `N_TEC_SET, `N_TEC_R:     parent = `N_TEC;
            `N_TEC_DT:                            parent = `N_TEC_DIS;
            `N_TEC_SR:                            parent = `N_TEC_SET;
            default:                              parent = `N_ROOT;
        endcase
    end

endmodule

// file: rtl/remote_common_cmd_tree_parser.v
`timescale 1ns/1ps
`include "cmd_tree_consts.vh"

module remote_common_cmd_tree_parser #(
    parameter AW            = 24,             // argument width, signed fixed point
    parameter FB            = 8,              // fraction bits of the argument
    parameter SW            = 32,             // width of one setup image
    parameter [SW-1:0] DEFAULT_SETUP = 32'h0000_0000
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          cmd_valid,
    output wire          cmd_ready,
    input  wire          cmd_common,
    input  wire [3:0]    cmd_op,
    input  wire          cmd_first,
    input  wire          cmd_abs,
    input  wire [1:0]    hdr_len,
    input  wire [3:0]    hdr_w0,
    input  wire [3:0]    hdr_w1,
    input  wire [3:0]    hdr_w2,
    input  wire [AW-1:0] cmd_arg,
    input  wire [SW-1:0] setup_in,
    output wire [SW-1:0] setup_out,
    output wire          setup_load,
    output wire          outputs_off,
    output wire          exec_valid,
    output wire [3:0]    exec_node,
    output wire [3:0]    cur_level,
    output wire [7:0]    sre_mask,
    input  wire [7:0]    stb_in,
    output wire          resp_valid,
    output wire [15:0]   resp_data,
    output wire          err_valid,
    output wire [7:0]    err_code,
    input  wire          no_op_pending,
    output wire          opc_done,
    output wire          selftest_start,
    input  wire          selftest_done,
    input  wire [15:0]   selftest_result
);

    // one-hot states
    localparam [3:0] S_IDLE = 4'b0001;   // ready for a command
    localparam [3:0] S_WALK = 4'b0010;   // resolving a header
    localparam [3:0] S_WAIT = 4'b0100;   // holding until nothing is pending
    localparam [3:0] S_TEST = 4'b1000;   // self-test running

    localparam [AW-1:0] HALF = {{(AW-1){1'b0}}, 1'b1} << (FB - 1);

    // round to nearest, halves away from zero, then drop the fraction
    function signed [AW-1:0] round_arg;
        input [AW-1:0] a;
        reg   [AW-1:0] m;
        begin
            m = a[AW-1] ? (~a + {{(AW-1){1'b0}}, 1'b1}) : a;
            m = (m + HALF) >> FB;
            round_arg = a[AW-1] ? (~m + {{(AW-1){1'b0}}, 1'b1}) : m;
        end
    endfunction

    // signed range check shared by all numeric commands
    function in_range;
        input signed [AW-1:0] v;
        input signed [15:0]   lo;
        input signed [15:0]   hi;
        begin
            in_range = (v >= lo) && (v <= hi);
        end
    endfunction

    // state and registered outputs
    reg [3:0]    state_q;             // controller state
    reg [SW-1:0] slot_mem [1:`SLOT_COUNT-1]; // saved setups; slot 0 is a constant
    reg [SW-1:0] setup_q;             // setup image last restored
    reg          load_q;              // setup_out valid strobe
    reg          off_q;               // both outputs off strobe
    reg          exec_q;              // resolved header strobe
    reg [3:0]    exec_node_q;         // resolved leaf node
    reg [3:0]    cur_q;               // remembered path level
    reg [3:0]    base_q;              // level where the current search starts
    reg [3:0]    node_q;              // node reached while descending
    reg [1:0]    idx_q;               // header word being matched
    reg [1:0]    len_q;               // header word count minus one
    reg [3:0]    w0_q;                // latched header words
    reg [3:0]    w1_q;
    reg [3:0]    w2_q;
    reg [7:0]    sre_q;               // service request enable mask
    reg          resp_q;              // response strobe
    reg [15:0]   resp_data_q;         // response value
    reg          err_q;               // error strobe
    reg [7:0]    err_code_q;          // error code
    reg          opc_pend_q;          // operation complete command armed
    reg          opc_done_q;          // operation complete event strobe
    reg          wait_resp_q;         // wait ends with a "1" answer
    reg          test_go_q;           // self-test start strobe

    wire signed [AW-1:0] rnd = round_arg(cmd_arg);
    wire [3:0]  slot   = rnd[3:0];
    wire        take   = cmd_valid && (state_q == S_IDLE);
    wire        rcl_ok = in_range(rnd, `RCL_MIN, `RCL_MAX);
    wire        sav_ok = in_range(rnd, `SAV_MIN, `SAV_MAX);
    wire        sre_ok = in_range(rnd, `SRE_MIN, `SRE_MAX);
    // summary from enabled bits; bit 6 of the incoming byte is ignored
    wire        mss    = |(stb_in & sre_q & ~`STB_MSS_MSK);
    wire [7:0]  stb    = {stb_in[7], mss, stb_in[5:0]};

    // word under test during the walk
    reg  [3:0]  cur_word;
    wire        lk_hit;
    wire [3:0]  lk_child;
    wire [3:0]  lk_parent;

    always @* begin
        case (idx_q)
            2'd0:    cur_word = w0_q;
            2'd1:    cur_word = w1_q;
            default: cur_word = w2_q;
        endcase
    end

    tree_lookup u_tree (
        .node    (node_q),
        .word    (cur_word),
        .up_node (base_q),
        .hit     (lk_hit),
        .child   (lk_child),
        .parent  (lk_parent)
    );

    assign cmd_ready      = (state_q == S_IDLE);
    assign setup_out      = setup_q;
    assign setup_load     = load_q;
    assign outputs_off    = off_q;
    assign exec_valid     = exec_q;
    assign exec_node      = exec_node_q;
    assign cur_level      = cur_q;
    assign sre_mask       = sre_q;
    assign resp_valid     = resp_q;
    assign resp_data      = resp_data_q;
    assign err_valid      = err_q;
    assign err_code       = err_code_q;
    assign opc_done       = opc_done_q;
    assign selftest_start = test_go_q;

    // slot memory has no reset; it stands in for non-volatile storage
    always @(posedge clk) begin
        if (take && cmd_common && cmd_op == `OP_SAV && sav_ok) begin
            slot_mem[slot] <= setup_in;
        end
    end

    // main controller
    always @(posedge clk) begin
        if (!rst_n) begin
            state_q     <= S_IDLE;
            setup_q     <= DEFAULT_SETUP;
            load_q      <= 1'b0;
            off_q       <= 1'b0;
            exec_q      <= 1'b0;
            exec_node_q <= `N_ROOT;
            cur_q       <= `N_ROOT;
            base_q      <= `N_ROOT;
            node_q      <= `N_ROOT;
            idx_q       <= 2'd0;
            len_q       <= 2'd0;
            w0_q        <= 4'h0;
            w1_q        <= 4'h0;
            w2_q        <= 4'h0;
            sre_q       <= `SRE_RST;
            resp_q      <= 1'b0;
            resp_data_q <= 16'h0000;
            err_q       <= 1'b0;
            err_code_q  <= 8'h00;
            opc_pend_q  <= 1'b0;
            opc_done_q  <= 1'b0;
            wait_resp_q <= 1'b0;
            test_go_q   <= 1'b0;
        end else begin
            // strobes default low
            load_q     <= 1'b0;
            off_q      <= 1'b0;
            exec_q     <= 1'b0;
            resp_q     <= 1'b0;
            err_q      <= 1'b0;
            opc_done_q <= 1'b0;
            test_go_q  <= 1'b0;

            // armed operation complete fires once nothing is pending
            if (opc_pend_q && no_op_pending) begin
                opc_pend_q <= 1'b0;
                opc_done_q <= 1'b1;
            end

            case (state_q)
                S_IDLE: begin
                    if (take && cmd_common) begin
                        // common commands leave cur_q alone
                        case (cmd_op)
                            `OP_RCL: begin
                                if (rcl_ok) begin
                                    setup_q <= (slot == `SLOT_DEF) ? DEFAULT_SETUP
                                               : slot_mem[slot];
                                    load_q  <= 1'b1;
                                    off_q   <= 1'b1;
                                end else begin
                                    err_q      <= 1'b1;
                                    err_code_q <= `ERR_PARAM;
                                end
                            end
                            `OP_RST: begin
                                setup_q     <= DEFAULT_SETUP;
                                load_q      <= 1'b1;
                                off_q       <= 1'b1;
                                opc_pend_q  <= 1'b0;
                                opc_done_q  <= 1'b0;
                                wait_resp_q <= 1'b0;
                                state_q     <= S_WAIT;
                            end
                            `OP_SAV: begin
                                if (!sav_ok) begin
                                    err_q      <= 1'b1;
                                    err_code_q <= `ERR_PARAM;
                                end
                            end
                            `OP_SRE: begin
                                if (sre_ok) begin
                                    sre_q <= rnd[7:0];
                                end else begin
                                    err_q      <= 1'b1;
                                    err_code_q <= `ERR_PARAM;
                                end
                            end
                            `OP_SRE_Q: begin
                                resp_q      <= 1'b1;
                                resp_data_q <= {8'h00, sre_q};
                            end
                            `OP_STB_Q: begin
                                resp_q      <= 1'b1;
                                resp_data_q <= {8'h00, stb};
                            end
                            `OP_TST_Q: begin
                                test_go_q <= 1'b1;
                                state_q   <= S_TEST;
                            end
                            `OP_WAI: begin
                                wait_resp_q <= 1'b0;
                                state_q     <= S_WAIT;
                            end
                            `OP_OPC: begin
                                opc_pend_q <= 1'b1;
                            end
                            `OP_OPC_Q: begin
                                wait_resp_q <= 1'b1;
                                state_q     <= S_WAIT;
                            end
                            default: begin
                                err_q      <= 1'b1;
                                err_code_q <= `ERR_UNDEF_HDR;
                            end
                        endcase
                    end else if (take) begin
                        // first command or leading colon starts at root,
                        // otherwise at the remembered level
                        w0_q   <= hdr_w0;
                        w1_q   <= hdr_w1;
                        w2_q   <= hdr_w2;
                        len_q  <= hdr_len;
                        idx_q  <= 2'd0;
                        if (cmd_first || cmd_abs) begin
                            base_q <= `N_ROOT;
                            node_q <= `N_ROOT;
                        end else begin
                            base_q <= cur_q;
                            node_q <= cur_q;
                        end
                        state_q <= S_WALK;
                    end
                end

                S_WALK: begin
                    if (lk_hit) begin
                        if (idx_q == len_q) begin
                            // leaf reached; its parent is the new level
                            exec_q      <= 1'b1;
                            exec_node_q <= lk_child;
                            cur_q       <= node_q;
                            state_q     <= S_IDLE;
                        end else begin
                            // descend only along spelled-out words
                            node_q <= lk_child;
                            idx_q  <= idx_q + 2'd1;
                        end
                    end else if (base_q == `N_ROOT) begin
                        err_q      <= 1'b1;
                        err_code_q <= `ERR_UNDEF_HDR;
                        state_q    <= S_IDLE;
                    end else begin
                        // restart the whole header one level up
                        base_q <= lk_parent;
                        node_q <= lk_parent;
                        idx_q  <= 2'd0;
                    end
                end

                S_WAIT: begin
                    // commands stay refused until nothing is pending
                    if (no_op_pending) begin
                        resp_q      <= wait_resp_q;
                        resp_data_q <= wait_resp_q ? `RESP_ONE : resp_data_q;
                        wait_resp_q <= 1'b0;
                        state_q     <= S_IDLE;
                    end
                end

                S_TEST: begin
                    // answer only once the test reports its end
                    if (selftest_done) begin
                        resp_q      <= 1'b1;
                        resp_data_q <= selftest_result;
                        state_q     <= S_IDLE;
                    end
                end

                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// file: tb/cmd_tree_sva.sv
`timescale 1ns/1ps
`include "cmd_tree_consts.vh"
// watches the command port and the state the parser drives back
module cmd_tree_sva #(
    parameter AW = 24                   // argument width
) (
    input wire          clk,
    input wire          rst_n,
    input wire          cmd_valid,
    input wire          cmd_ready,
    input wire          cmd_common,
    input wire [3:0]    cmd_op,
    input wire [AW-1:0] cmd_arg,
    input wire [31:0]   setup_out,
    input wire          setup_load,
    input wire          outputs_off,
    input wire          exec_valid,
    input wire          err_valid,
    input wire [7:0]    err_code,
    input wire [3:0]    cur_level,
    input wire [7:0]    sre_mask,
    input wire [7:0]    stb_in,
    input wire          resp_valid,
    input wire [15:0]   resp_data,
    input wire          no_op_pending,
    input wire          opc_done,
    input wire          selftest_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = cmd_valid && cmd_ready && cmd_common; // common command taken at this edge

    load_off_a: assert property (setup_load |-> outputs_off)
        else $error("outputs left on after a restore");
    rst_default_a: assert property (take && cmd_op == `OP_RST
        |=> setup_load && setup_out == 0) else $error("reset did not load defaults");
    rst_settle_a: assert property (take && cmd_op == `OP_RST && !no_op_pending
        |=> !cmd_ready) else $error("reset accepted more while pending");
    sre_load_a: assert property (take && cmd_op == `OP_SRE && cmd_arg[23:16] == 0
        && cmd_arg[7:0] == 0 |=> sre_mask == $past(cmd_arg[15:8])) else $error("mask not loaded");
    sre_echo_a: assert property (take && cmd_op == `OP_SRE_Q
        |=> resp_valid && resp_data == {8'h00, sre_mask}) else $error("mask query wrong");
    stb_summary_a: assert property (take && cmd_op == `OP_STB_Q
        |=> resp_data[6] == |($past(stb_in) & sre_mask & 8'hbf)) else $error("summary wrong");
    test_start_a: assert property (take && cmd_op == `OP_TST_Q
        |=> selftest_start && !cmd_ready) else $error("self-test not started");
    wait_block_a: assert property (take && cmd_op == `OP_WAI && !no_op_pending
        |=> !cmd_ready) else $error("wait did not block");
    hdr_bound_a: assert property (cmd_valid && cmd_ready && !cmd_common
        |-> ##[2:12] (exec_valid || err_valid)) else $error("header never resolved");
    level_keep_a: assert property (take && cmd_op != `OP_RST |=> $stable(cur_level))
        else $error("common command moved the level");
    neg_refuse_a: assert property (take && (cmd_op == `OP_RCL || cmd_op == `OP_SAV)
        && cmd_arg[23] && cmd_arg[22:8] != 15'h7fff
        |=> err_valid && err_code == `ERR_PARAM && !setup_load)
        else $error("negative slot accepted");
    opc_idle_a: assert property (opc_done |-> $past(no_op_pending))
        else $error("operation complete while pending");
endmodule
bind remote_common_cmd_tree_parser cmd_tree_sva #(.AW(AW)) u_sva (.*);

// file: tb/device_side_model.sv
`timescale 1ns/1ps
// far-side stand-in: pending-operation flag and self-test engine
module device_side_model (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        busy_go,         // loads busy_len while high; pulse it
    input  wire [7:0]  busy_len,        // cycles the operation stays pending
    input  wire        selftest_start,
    input  wire [15:0] fail_code,       // value the self-test reports
    output wire        no_op_pending,
    output wire        selftest_done,
    output wire [15:0] selftest_result
);
    reg [7:0] busy_q;                   // cycles left pending
    reg [4:0] test_q;                   // cycles left in the self-test
    // both run down to zero; busy_len sets prompt or slow answers
    always @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 8'h00;
            test_q <= 5'h00;
        end else begin
            busy_q <= busy_go ? busy_len : busy_q - {7'h00, busy_q != 8'h00};
            test_q <= selftest_start ? {1'b0, busy_len[3:0]} + 5'h02
                                     : test_q - {4'h0, test_q != 5'h00};
        end
    end
    assign no_op_pending   = busy_q == 8'h00;
    assign selftest_done   = test_q == 5'h01;
    // result is only valid with done; inverted otherwise so a late read shows
    assign selftest_result = selftest_done ? fail_code : ~fail_code;
endmodule

// file: tb/remote_common_cmd_tree_parser_bench.sv
`timescale 1ns/1ps
`include "cmd_tree_consts.vh"
module remote_common_cmd_tree_parser_bench;
    logic        clk, rst_n, cmd_valid, cmd_common, cmd_first, cmd_abs, busy_go;
    logic [3:0]  cmd_op, hdr_w0, hdr_w1, hdr_w2;
    logic [1:0]  hdr_len;
    logic [23:0] cmd_arg, a;            // a: argument under test
    logic [31:0] setup_in, saved [1:10];
    logic [7:0]  stb_in, busy_len, mask;  // mask: expected enable mask
    logic [15:0] fail_code;
    wire         cmd_ready, setup_load, outputs_off, exec_valid, resp_valid, err_valid;
    wire         opc_done, selftest_start, selftest_done, no_op_pending;
    wire [31:0]  setup_out;
    wire [3:0]   exec_node, cur_level;
    wire [7:0]   sre_mask, err_code;
    wire [15:0]  resp_data, selftest_result;
    integer      n_fail, n_compared, i;

    remote_common_cmd_tree_parser u_dut (.*);
    device_side_model u_dev (.*);

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // rounding to nearest, halves away from zero
    function automatic integer rnd(input logic [23:0] v);
        integer s;
        s = $signed(v);
        rnd = (s >= 0) ? (s + 128) >>> 8 : -((128 - s) >>> 8);
    endfunction

    // status byte with the summary in bit 6
    function automatic logic [7:0] stb_exp(input logic [7:0] s, input logic [7:0] m);
        stb_exp = {s[7], |(s & m & 8'hbf), s[5:0]};
    endfunction

    task give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a wait that ran out ends the run
    task lost;
        n_fail = n_fail + 1;
        give_verdict;
    endtask

    task step;
        @(posedge clk);
        #1;
    endtask

    // offer a command and hold it until the edge that takes it
    task send(input logic com, input logic [3:0] op, input logic [23:0] arg, input logic fst, ab,
              input logic [1:0] len, input logic [3:0] w0, w1, w2);
        integer k;
        step;
        cmd_valid = 1'b1;
        {cmd_common, cmd_op, cmd_arg, cmd_first, cmd_abs} = {com, op, arg, fst, ab};
        {hdr_len, hdr_w0, hdr_w1, hdr_w2} = {len, w0, w1, w2};
        k = 0;
        do begin
            @(negedge clk);
            k = k + 1;
        end while (!cmd_ready && k < 300);
        step;
        cmd_valid = 1'b0;
        if (k >= 300) lost;
    endtask

    task cmd(input logic [3:0] op, input logic [23:0] arg);
        send(1'b1, op, arg, 1'b0, 1'b0, 2'h0, 4'h0, 4'h0, 4'h0);
    endtask

    // bounded wait for a pulse: 0 response, 1 error, 2 execute, 3 restore, 4 complete, 5 ready
    task await(input integer sel);
        integer k;
        k = 0;
        do begin
            @(negedge clk);
            k = k + 1;
        end while (!(sel == 0 ? resp_valid : sel == 1 ? err_valid : sel == 2 ? exec_valid :
                   sel == 3 ? setup_load : sel == 4 ? opc_done : cmd_ready) && k < 300);
        if (k >= 300) lost;
    endtask

    // one header of a string; nd 4'hf means an undefined header
    task hdr(input logic fst, ab, input logic [1:0] len, input logic [3:0] w0, w1, w2, nd);
        send(1'b0, 4'h0, 24'h0, fst, ab, len, w0, w1, w2);
        await(nd == 4'hf ? 1 : 2);
        check(nd == 4'hf ? err_code : exec_node, nd == 4'hf ? `ERR_UNDEF_HDR : nd);
    endtask

    // once idle, start a pending operation, then issue op while it runs
    task pend(input logic [3:0] op);
        await(5);
        step;
        busy_go = 1'b1;
        step;
        busy_go = 1'b0;
        cmd(op, 24'h0);
    endtask

    initial begin
        {cmd_valid, cmd_common, cmd_op, cmd_first, cmd_abs, hdr_len, hdr_w0, hdr_w1, hdr_w2} = '0;
        {cmd_arg, setup_in, stb_in, busy_go, fail_code} = '0;
        busy_len = 8'd20;
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        i = $urandom(72);
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        check({sre_mask, cur_level, setup_out}, 0);
        // enable masks: halves, boundary, then random fractions
        mask = 8'h00;
        for (i = 0; i < 10; i = i + 1) begin
            a = i == 0 ? 24'h000280 : i == 1 ? 24'hffff80 :
                i == 2 ? 24'h00ff00 : {8'h00, 16'($urandom)};
            cmd(`OP_SRE, a);
            stb_in = 8'($urandom);
            @(negedge clk);
            check(err_valid, rnd(a) > 255 || rnd(a) < 0);
            if (rnd(a) <= 255 && rnd(a) >= 0) mask = 8'(rnd(a));
            cmd(`OP_SRE_Q, 24'h0);
            await(0);
            check(resp_data, {8'h00, mask});
            cmd(`OP_STB_Q, 24'h0);
            await(0);
            check(resp_data[7:0], stb_exp(stb_in, mask));
        end
        // fill every slot, then restore in reverse with a fraction that rounds down
        for (i = 1; i <= 10; i = i + 1) begin
            setup_in = $urandom;
            saved[i] = setup_in;
            cmd(`OP_SAV, {8'h00, 8'(i), 8'h00});
        end
        for (i = 10; i >= 0; i = i - 1) begin
            cmd(`OP_RCL, {8'h00, 8'(i), 8'h66});
            await(3);
            check(outputs_off, 1'b1);
            check(setup_out, i > 0 ? saved[i] : 32'h0);
        end
        // refused slots leave the restored image alone
        for (i = 0; i < 3; i = i + 1) begin
            cmd(i == 0 ? `OP_SAV : `OP_RCL, i == 0 ? 24'h0 : i == 1 ? 24'h000b00 : 24'hfffe00);
            await(1);
            check({err_code, setup_out}, {`ERR_PARAM, 32'h0});
        end
        // reset and wait both hold off later commands while busy
        pend(`OP_RST);
        @(negedge clk);
        check({setup_load, outputs_off, setup_out}, {2'b11, 32'h0});
        check(cmd_ready, 1'b0);
        pend(`OP_WAI);
        @(negedge clk);
        check(cmd_ready, 1'b0);
        pend(`OP_OPC);
        await(4);
        check(no_op_pending, 1'b1);
        pend(`OP_OPC_Q);
        await(0);
        check({no_op_pending, resp_data}, {1'b1, `RESP_ONE});
        // self-test passes, then fails with a random code
        for (i = 0; i < 2; i = i + 1) begin
            fail_code = i ? (16'($urandom) | 16'h0001) : 16'h0000;
            cmd(`OP_TST_Q, 24'h0);
            await(0);
            check(resp_data, fail_code);
        end
        // tree walking through remembered levels
        hdr(1'b1, 1'b0, 2'd2, `W_LAS, `W_DIS, `W_SET, `N_LAS_DS);
        check(cur_level, `N_LAS_DIS);
        hdr(1'b0, 1'b0, 2'd0, `W_OUT, 4'h0, 4'h0, `N_LAS_OUT);
        check(cur_level, `N_LAS);
        hdr(1'b1, 1'b0, 2'd2, `W_TEC, `W_SET, `W_R, `N_TEC_SR);
        hdr(1'b0, 1'b0, 2'd0, `W_R, 4'h0, 4'h0, `N_TEC_SR);
        hdr(1'b1, 1'b0, 2'd2, `W_TEC, `W_DIS, `W_T, `N_TEC_DT);
        cmd(`OP_SRE_Q, 24'h0);
        await(0);
        check(cur_level, `N_TEC_DIS);
        hdr(1'b0, 1'b0, 2'd0, `W_SET, 4'h0, 4'h0, `N_TEC_SET);
        hdr(1'b1, 1'b0, 2'd2, `W_LAS, `W_DIS, `W_SET, `N_LAS_DS);
        hdr(1'b0, 1'b0, 2'd0, `W_DEC, 4'h0, 4'h0, `N_LAS_DEC);
        hdr(1'b0, 1'b0, 2'd1, `W_DIS, `W_T, 4'h0, 4'hf);
        hdr(1'b0, 1'b1, 2'd2, `W_TEC, `W_DIS, `W_T, `N_TEC_DT);
        give_verdict;
    end
endmodule
